// File: cpfs_supervisor.v
/*
 * Protection and fault supervisor: synchronises comparator events, gates
 * converter and battery switch, runs the boost hiccup timer, latches fault
 * flags, pulses a low interrupt, and offers control and fault over APB.
 * Assumes comparator inputs are levels, asynchronous to clk.
 */
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "cpfs_map.vh"

module cpfs_supervisor #(
    parameter [21:0] HIC_OFF_CYC = `CPFS_HIC_OFF_CYC,
    parameter [21:0] HIC_ON_CYC  = `CPFS_HIC_ON_CYC,
    parameter [21:0] INT_CYC     = `CPFS_INT_CYC,
    parameter [21:0] BTN_CYC     = `CPFS_BTN_CYC
) (
    // Clock, reset, enable
    input  wire        clk,
    input  wire        arst_n,
    input  wire        clk_en,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    // Analog events
    input  wire        therm_reg_cmp,
    input  wire        therm_shut_cmp,
    input  wire        therm_hys_cmp,
    input  wire        input_overvoltage,
    input  wire        system_overvoltage,
    input  wire        boost_oc_cmp,
    input  wire        boost_ov_cmp,
    input  wire        battery_overvoltage,
    input  wire        bat_overdischarge,
    input  wire        bat_short_cmp,
    input  wire        bat_low_cmp,
    input  wire        sys_overcurrent,
    input  wire        adapter_present,
    input  wire        push_button_pin,
    // Power stage controls and interrupt
    output reg         converter_en,
    output reg         battery_switch,
    output reg         reverse_block_switch,
    output reg         charge_en,
    output reg         charge_reduce,
    output reg  [1:0]  thermal_reg_limit,
    output reg         termination_en,
    output reg         safety_timer_half,
    output reg  [1:0]  charge_current_sel,
    output reg         int_n
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    localparam NSYNC = 14;
    wire [NSYNC-1:0] raw_in = {push_button_pin, adapter_present, sys_overcurrent,
        bat_low_cmp, bat_short_cmp, bat_overdischarge, battery_overvoltage,
        boost_ov_cmp, boost_oc_cmp, system_overvoltage, input_overvoltage,
        therm_hys_cmp, therm_shut_cmp, therm_reg_cmp};
    reg  [NSYNC-1:0] sync1_reg;
    reg  [NSYNC-1:0] sync2_reg;

    // Two flops; first stage feeds only the second
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= {1'b1, {(NSYNC-1){1'b0}}}; // Button idles high, no false press
            sync2_reg <= {1'b1, {(NSYNC-1){1'b0}}};
        end else if (clk_en) begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    wire s_thermal_reg_limit   = sync2_reg[0];
    wire s_tshut  = sync2_reg[1];
    wire s_thys   = sync2_reg[2];
    wire s_inov   = sync2_reg[3];
    wire s_sysov  = sync2_reg[4];
    wire s_boc    = sync2_reg[5];
    wire s_bov    = sync2_reg[6];
    wire s_batov  = sync2_reg[7];
    wire s_odis   = sync2_reg[8];
    wire s_short  = sync2_reg[9];
    wire s_low    = sync2_reg[10];
    wire s_sysoc  = sync2_reg[11];
    wire s_adapt  = sync2_reg[12];
    wire s_btn    = sync2_reg[13];

    // ************************************************************
    // APB register file
    // ************************************************************
    reg  [31:0] ctrl_reg;
    reg  [3:0]  fault_reg;
    reg         fault_read_reg;
    reg         tshut_reg;
    reg         boost_tshut_reg;
    reg  [1:0]  hic_st_reg;
    reg         odis_reg;
    reg         bsw_latch_reg;
    wire        apb_acc   = psel & penable;
    wire        wr_ctrl   = apb_acc & pwrite & (paddr == `CPFS_OFS_CTRL);
    wire        rd_fault  = apb_acc & ~pwrite & (paddr == `CPFS_OFS_FAULT);
    wire        map_hit   = (paddr == `CPFS_OFS_CTRL) | (paddr == `CPFS_OFS_FAULT) |
                            (paddr == `CPFS_OFS_STATUS);
    wire        reg_rst   = wr_ctrl & pwdata[`CPFS_CTRL_REG_RST];
    wire        boost_en  = ctrl_reg[`CPFS_CTRL_BOOST_EN];
    wire        bsw_dis   = ctrl_reg[`CPFS_CTRL_BSW_DIS];
    wire        boost_kill;

    // Zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = apb_acc & ~map_hit;

    // Hardware clear of boost enable wins over a same-cycle host write
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= `CPFS_CTRL_RESET;
        end else if (clk_en) begin
            if (reg_rst)
                ctrl_reg <= `CPFS_CTRL_RESET;
            else if (wr_ctrl)
                ctrl_reg <= {26'h000_0000, pwdata[5:4], 2'b00, pwdata[1:0]};
            if (boost_kill)
                ctrl_reg[`CPFS_CTRL_BOOST_EN] <= 1'b0;
        end
    end

    // Read data register
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && psel && !penable && !pwrite) begin
            case (paddr)
                `CPFS_OFS_CTRL:   prdata <= ctrl_reg;
                `CPFS_OFS_FAULT:  prdata <= {28'h000_0000, fault_reg};
                `CPFS_OFS_STATUS: prdata <= {26'h000_0000, hic_st_reg, s_thermal_reg_limit,
                                             bsw_latch_reg, odis_reg, tshut_reg};
                default:          prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // Thermal handling
    // ************************************************************
    // Shutdown holds until die cools; a boost trip waits for host re-enable
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tshut_reg       <= 1'b0;
            boost_tshut_reg <= 1'b0;
        end else if (clk_en) begin
            if (s_tshut) begin
                tshut_reg       <= 1'b1;
                boost_tshut_reg <= boost_tshut_reg | boost_en;
            end else begin
                if (s_thys)
                    tshut_reg <= 1'b0;
                if (boost_en)
                    boost_tshut_reg <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Boost hiccup timer
    // ************************************************************
    localparam HIC_IDLE = 2'd0;
    localparam HIC_OFF  = 2'd1;
    localparam HIC_ON   = 2'd2;
    reg  [21:0] hic_cnt_reg;
    wire        boost_act = boost_en & ~tshut_reg;

    // Retry window lets an overload clear without host help
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hic_st_reg  <= HIC_IDLE;
            hic_cnt_reg <= 22'h00_0000;
        end else if (clk_en) begin
            case (hic_st_reg)
                HIC_IDLE: begin
                    if (boost_act && s_boc) begin
                        hic_st_reg  <= HIC_OFF;
                        hic_cnt_reg <= HIC_OFF_CYC - 22'h00_0001;
                    end
                end
                HIC_OFF: begin
                    if (!boost_act)
                        hic_st_reg <= HIC_IDLE;
                    else if (hic_cnt_reg == 22'h00_0000) begin
                        hic_st_reg  <= HIC_ON;
                        hic_cnt_reg <= HIC_ON_CYC - 22'h00_0001;
                    end else
                        hic_cnt_reg <= hic_cnt_reg - 22'h00_0001;
                end
                HIC_ON: begin
                    if (!boost_act || !s_boc)
                        hic_st_reg <= HIC_IDLE;
                    else if (hic_cnt_reg == 22'h00_0000) begin
                        hic_st_reg  <= HIC_OFF;
                        hic_cnt_reg <= HIC_OFF_CYC - 22'h00_0001;
                    end else
                        hic_cnt_reg <= hic_cnt_reg - 22'h00_0001;
                end
                default: hic_st_reg <= HIC_IDLE;
            endcase
        end
    end

    assign boost_kill = boost_en & (s_bov | s_tshut);

    // ************************************************************
    // Battery switch latches
    // ************************************************************
    reg  [21:0] btn_cnt_reg;
    reg         btn_low_reg;
    reg         btn_fall;
    reg         bsw_dis_d_reg;

    // Push-button fall deglitched by a low-time counter
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            btn_cnt_reg   <= 22'h00_0000;
            btn_low_reg   <= 1'b0;
            btn_fall      <= 1'b0;
            bsw_dis_d_reg <= 1'b0;
        end else if (clk_en) begin
            bsw_dis_d_reg <= bsw_dis;
            btn_fall      <= 1'b0;
            if (s_btn) begin
                btn_cnt_reg <= 22'h00_0000;
                btn_low_reg <= 1'b0;
            end else if (!btn_low_reg) begin
                if (btn_cnt_reg == BTN_CYC - 22'h00_0001) begin
                    btn_low_reg <= 1'b1;
                    btn_fall    <= 1'b1;
                end else
                    btn_cnt_reg <= btn_cnt_reg + 22'h00_0001;
            end
        end
    end

    wire exit_evt = s_adapt | (bsw_dis_d_reg & ~bsw_dis) | reg_rst | btn_fall;

    // Overcurrent latch survives until a shipping-mode exit
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            odis_reg      <= 1'b0;
            bsw_latch_reg <= 1'b0;
        end else if (clk_en) begin
            if (s_odis && !s_adapt)
                odis_reg <= 1'b1;
            else if (s_adapt)
                odis_reg <= 1'b0;
            if (s_sysoc)
                bsw_latch_reg <= 1'b1;
            else if (exit_evt)
                bsw_latch_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Fault flags and interrupt
    // ************************************************************
    reg  [21:0] int_cnt_reg;
    wire        boost_evt = boost_act & (s_boc | s_bov);
    wire [3:0]  fault_now = {s_batov, boost_evt,
                             s_tshut ? `CPFS_CODE_TSHUT :
                             s_inov ? `CPFS_CODE_INOV : `CPFS_CODE_NONE};
    wire        armed     = (fault_reg == 4'h0) & ~fault_read_reg;

    // Flags hold until read; set wins over the read clear
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_reg      <= 4'h0;
            fault_read_reg <= 1'b0;
            int_cnt_reg    <= 22'h00_0000;
            int_n          <= 1'b1;
        end else if (clk_en) begin
            fault_read_reg <= 1'b0;
            if (rd_fault) begin
                fault_reg      <= fault_now;
                fault_read_reg <= 1'b1;
            end else begin
                fault_reg[`CPFS_FLT_BAT:`CPFS_FLT_BOOST] <= fault_now[`CPFS_FLT_BAT:`CPFS_FLT_BOOST] |
                    fault_reg[`CPFS_FLT_BAT:`CPFS_FLT_BOOST];
                if (fault_reg[`CPFS_FLT_CODE_HI:`CPFS_FLT_CODE_LO] == `CPFS_CODE_NONE)
                    fault_reg[`CPFS_FLT_CODE_HI:`CPFS_FLT_CODE_LO] <= fault_now[1:0];
            end
            if (armed && fault_now != 4'h0 && int_n) begin
                int_n       <= 1'b0;
                int_cnt_reg <= INT_CYC - 22'h00_0001;
            end else if (!int_n) begin
                if (int_cnt_reg == 22'h00_0000)
                    int_n <= 1'b1;
                else
                    int_cnt_reg <= int_cnt_reg - 22'h00_0001;
            end
        end
    end

    // ************************************************************
    // Power stage outputs
    // ************************************************************
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            converter_en         <= 1'b0;
            battery_switch       <= 1'b0;
            reverse_block_switch <= 1'b0;
            charge_en            <= 1'b0;
            charge_reduce        <= 1'b0;
            thermal_reg_limit    <= 2'b00;
            termination_en       <= 1'b1;
            safety_timer_half    <= 1'b0;
            charge_current_sel   <= `CPFS_ICHG_FAST;
        end else if (clk_en) begin
            converter_en   <= ~tshut_reg & ~boost_tshut_reg & ~s_tshut & ~s_inov &
                              ~s_sysov & ~s_bov;
            battery_switch <= ~tshut_reg & ~s_tshut & ~odis_reg & ~bsw_latch_reg &
                              ~bsw_dis & ~s_sysoc;
            reverse_block_switch <= (hic_st_reg != HIC_OFF);
            charge_en      <= ~s_batov & ~tshut_reg & ~boost_en;
            thermal_reg_limit <= ctrl_reg[`CPFS_CTRL_THERMAL_REG_LIMIT_HI:`CPFS_CTRL_THERMAL_REG_LIMIT_LO];
            charge_reduce  <= s_thermal_reg_limit;
            termination_en <= ~s_thermal_reg_limit;
            safety_timer_half <= s_thermal_reg_limit;
            charge_current_sel <= !s_short ? `CPFS_ICHG_SHORT :
                                  !s_low ? `CPFS_ICHG_PRE : `CPFS_ICHG_FAST;
        end
    end

endmodule // cpfs_supervisor

// File: cpfs_map.vh
/*
 * Constants for the charger protection and fault supervisor: register
 * offsets on APB, field positions, reset values and timing counts.
 * Assumes a 100 MHz core clock and a 32-bit APB master.
 */
`ifndef CPFS_MAP_VH
`define CPFS_MAP_VH
// Register byte offsets
`define CPFS_OFS_CTRL      12'h000
`define CPFS_OFS_FAULT     12'h004
`define CPFS_OFS_STATUS    12'h008
// Control fields
`define CPFS_CTRL_BOOST_EN 0
`define CPFS_CTRL_BSW_DIS  1
`define CPFS_CTRL_REG_RST  2
`define CPFS_CTRL_THERMAL_REG_LIMIT_LO  4
`define CPFS_CTRL_THERMAL_REG_LIMIT_HI  5
`define CPFS_CTRL_RESET    32'h0000_0000
// Fault fields
`define CPFS_FLT_CODE_LO   0
`define CPFS_FLT_CODE_HI   1
`define CPFS_FLT_BOOST     2
`define CPFS_FLT_BAT       3
`define CPFS_CODE_NONE     2'b00
`define CPFS_CODE_INOV     2'b01
`define CPFS_CODE_TSHUT    2'b10
// Charge current selects
`define CPFS_ICHG_FAST     2'b00
`define CPFS_ICHG_SHORT    2'b01
`define CPFS_ICHG_PRE      2'b10
// Timing, figures as printed and cycle counts at 100 MHz
`define CPFS_CLK_MHZ       100
`define CPFS_HIC_OFF_MS    30
`define CPFS_HIC_ON_US     250
`define CPFS_INT_US        256
`define CPFS_HIC_OFF_CYC   (`CPFS_HIC_OFF_MS * 1000 * `CPFS_CLK_MHZ)
`define CPFS_HIC_ON_CYC    (`CPFS_HIC_ON_US * `CPFS_CLK_MHZ)
`define CPFS_INT_CYC       (`CPFS_INT_US * `CPFS_CLK_MHZ)
`define CPFS_BTN_CYC       1000
`define CPFS_CNT_W         22
`endif

// File: cpfs_host.sv
/* Host model: an APB master driven by the bench, one transfer at a time.
   Assumes callers enter right after a rising clock edge. */
`timescale 1ns/1ps
// ****************
// Host bus model
// ****************
module cpfs_host (
    // Clock and answer
    input  wire logic        clk,
    input  wire logic        pready,
    // Request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata
);
    // Bus idle from time zero
    initial {psel, penable, pwrite, paddr, pwdata} = '0;

    // Setup, then access held until pready is seen high at an edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;  // Released data must not look still valid
        @(posedge clk);
    endtask
endmodule // cpfs_host

// File: cpfs_sup_chk.sv
/* Checker: fault response times, interrupt pulse width, limit copy.
   Assumes it is bound to cpfs_supervisor with clk_en held high. */
`timescale 1ns/1ps
// ********
// Checker
// ********
module cpfs_sup_chk #(
    parameter [21:0] INT_CYC = 22'h00_001e
) (
    // Clock and reset
    input wire        clk,
    input wire        arst_n,
    // Bus
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    // Events
    input wire        therm_shut_cmp,
    input wire        input_overvoltage,
    input wire        system_overvoltage,
    input wire        battery_overvoltage,
    input wire        sys_overcurrent,
    // Outputs
    input wire        converter_en,
    input wire        battery_switch,
    input wire        charge_en,
    input wire [1:0]  thermal_reg_limit,
    input wire        int_n
);
    logic [21:0] lo_cnt;
    logic [1:0]  lim_q;

    // Cycles int_n has been low; read at the rising edge, before it clears
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) lo_cnt <= 22'h00_0000;
        else lo_cnt <= int_n ? 22'h00_0000 : lo_cnt + 22'h00_0001;
    end

    // Last limit code written to the control register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) lim_q <= 2'h0;
        else if (psel && penable && pwrite && paddr == 12'h000) lim_q <= pwdata[5:4];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    int_width_a: assert property (
        $rose(int_n) |-> lo_cnt == INT_CYC) else $error("interrupt pulse length wrong");
    int_cap_a: assert property (
        lo_cnt <= INT_CYC) else $error("interrupt pulse too long");
    inov_stop_a: assert property (
        $rose(input_overvoltage) |-> ##[1:5] !converter_en) else $error("input ov: converter on");
    sysov_stop_a: assert property (
        $rose(system_overvoltage) |-> ##[1:5] !converter_en) else $error("sys ov: converter on");
    tshut_off_a: assert property (
        $rose(therm_shut_cmp) |-> ##[1:5] (!converter_en && !battery_switch))
        else $error("switches on after thermal shutdown");
    batov_stop_a: assert property (
        $rose(battery_overvoltage) |-> ##[1:5] !charge_en) else $error("charging after bat ov");
    sysoc_latch_a: assert property (
        $rose(sys_overcurrent) |-> ##[1:5] !battery_switch) else $error("switch on after sys oc");
    lim_copy_a: assert property (
        psel && penable && pwrite && paddr == 12'h000 && !pwdata[2]
        |-> ##[1:2] thermal_reg_limit == lim_q) else $error("thermal limit not copied");
endmodule // cpfs_sup_chk

bind cpfs_supervisor cpfs_sup_chk #(.INT_CYC(INT_CYC)) i_cpfs_sup_chk (
    .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .therm_shut_cmp,
    .input_overvoltage, .system_overvoltage, .battery_overvoltage, .sys_overcurrent,
    .converter_en, .battery_switch, .charge_en, .thermal_reg_limit, .int_n);

// File: tb_top.sv
/* Bench for the protection supervisor: drives events and APB, checks pins and reads.
   Assumes the host model for bus cycles and shortened hiccup and pulse counts. */
`timescale 1ns/1ps
// ********
// Bench
// ********
module tb_top;
    localparam logic [21:0] HOFF = 22'h00_00c8, HON = 22'h00_0032;
    localparam logic [21:0] INTC = 22'h00_001e, BTN = 22'h00_0005;
    logic        clk, arst_n, adapter_present, push_button_pin, therm_reg_cmp, therm_shut_cmp;
    logic        therm_hys_cmp, input_overvoltage, system_overvoltage, boost_oc_cmp;
    logic        boost_ov_cmp, battery_overvoltage, bat_overdischarge, bat_short_cmp;
    logic        bat_low_cmp, sys_overcurrent;
    wire         psel, penable, pwrite, pready, pslverr, converter_en, battery_switch;
    wire         reverse_block_switch, charge_en, charge_reduce, termination_en;
    wire         safety_timer_half, int_n;
    wire  [11:0] paddr;
    wire  [31:0] pwdata, prdata;
    wire  [1:0]  thermal_reg_limit, charge_current_sel;
    int          error_cnt = 0, n_tests = 0, cyc = 0;
    logic [32:0] exp_q[$];
    logic [32:0] e_cur;
    logic [15:0] lfsr;

    cpfs_supervisor #(.HIC_OFF_CYC(HOFF), .HIC_ON_CYC(HON), .INT_CYC(INTC), .BTN_CYC(BTN))
    i_cpfs_supervisor (.clk, .arst_n, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .pslverr, .prdata, .therm_reg_cmp, .therm_shut_cmp, .therm_hys_cmp,
        .input_overvoltage, .system_overvoltage, .boost_oc_cmp, .boost_ov_cmp,
        .battery_overvoltage, .bat_overdischarge, .bat_short_cmp, .bat_low_cmp,
        .sys_overcurrent, .adapter_present, .push_button_pin, .converter_en, .battery_switch,
        .reverse_block_switch, .charge_en, .charge_reduce, .thermal_reg_limit, .termination_en,
        .safety_timer_half, .charge_current_sel, .int_n);
    cpfs_host i_cpfs_host (.clk, .pready, .psel, .penable, .pwrite, .paddr, .pwdata);

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checks=%0d errors=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Read results against the oldest note; an empty queue forces a miss
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite) begin
            e_cur = (exp_q.size() > 0) ? exp_q.pop_front() : {1'b1, 32'hffff_ffff};
            check(prdata, e_cur[31:0]);
            check(pslverr, e_cur[32]);
        end
    end

    // Hang guard; the run needs about a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            final_report;
        end
    end

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic pick(input int s);
        return (s == 0) ? int_n : reverse_block_switch;
    endfunction
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        i_cpfs_host.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic err);
        @(posedge clk);
        exp_q.push_back({err, d});
        i_cpfs_host.xfer(1'b0, a, 32'h0000_0000);
    endtask
    // Latched value first, present value second
    task automatic fault2(input logic [31:0] first);
        rd(12'h004, first, 1'b0);
        rd(12'h004, 32'h0000_0000, 1'b0);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    // Length of the next stretch at level lv on int_n (0) or the reverse switch (1)
    task automatic meas(input int s, input logic lv, output int w);
        w = 0;
        for (int k = 0; k < 300 && pick(s) !== lv; k++) @(negedge clk);
        while (pick(s) === lv && w < 400) begin
            w++;
            @(negedge clk);
        end
    endtask

    // Main sequence
    initial begin
        int w;
        lfsr = 16'h0c7b;
        arst_n = 1'b0;
        {therm_reg_cmp, therm_shut_cmp, therm_hys_cmp, input_overvoltage, system_overvoltage,
         boost_oc_cmp, boost_ov_cmp, battery_overvoltage, bat_overdischarge} = '0;
        sys_overcurrent = 1'b0;
        {bat_short_cmp, bat_low_cmp, adapter_present, push_button_pin} = 4'hf;
        repeat (5) @(posedge clk);
        @(negedge clk);
        check({termination_en, int_n, converter_en}, 3'b110);
        @(posedge clk) arst_n <= 1'b1;
        settle(4);
        rd(12'h00c, 32'h0000_0000, 1'b1);
        wr(12'h004, 32'hffff_ffff);
        rd(12'h004, 32'h0000_0000, 1'b0);
        repeat (4) begin
            lfsr = nxt(lfsr);
            wr(12'h000, {16'h0000, lfsr & 16'h0030});
            rd(12'h000, {16'h0000, lfsr & 16'h0030}, 1'b0);
            check(thermal_reg_limit, lfsr[5:4]);
        end
        // Input overvoltage, then a second fault while the first is unread
        @(posedge clk) input_overvoltage <= 1'b1;
        meas(0, 1'b0, w);
        check(w, INTC);
        check(converter_en, 1'b0);
        @(posedge clk) battery_overvoltage <= 1'b1;
        settle(8);
        check(int_n, 1'b1);
        check(charge_en, 1'b0);
        @(posedge clk) input_overvoltage <= 1'b0;
        battery_overvoltage <= 1'b0;
        settle(4);
        fault2(32'h0000_0009);
        // Thermal shutdown in buck, then in boost without an adapter
        for (int m = 0; m < 2; m++) begin
            wr(12'h000, m);
            adapter_present <= (m == 0);
            @(posedge clk) therm_shut_cmp <= 1'b1;
            settle(6);
            check({converter_en, battery_switch}, 2'b00);
            rd(12'h000, 32'h0000_0000, 1'b0);
            @(posedge clk) therm_shut_cmp <= 1'b0;
            therm_hys_cmp <= 1'b1;
            settle(6);
            check({converter_en, battery_switch}, {m == 0, 1'b1});
            fault2(32'h0000_0002);
            if (m == 1) begin
                wr(12'h000, 32'h0000_0001);
                settle(4);
                check(converter_en, 1'b1);
            end
            @(posedge clk) therm_hys_cmp <= 1'b0;
        end
        adapter_present <= 1'b1;
        // Thermal regulation flags and status
        @(posedge clk) therm_reg_cmp <= 1'b1;
        settle(5);
        check({charge_reduce, safety_timer_half, termination_en}, 3'b110);
        rd(12'h008, 32'h0000_0008, 1'b0);
        @(posedge clk) therm_reg_cmp <= 1'b0;
        system_overvoltage <= 1'b1;
        settle(5);
        check({converter_en, termination_en}, 2'b01);
        @(posedge clk) system_overvoltage <= 1'b0;
        // Boost overcurrent hiccup; boost is still enabled
        @(posedge clk) boost_oc_cmp <= 1'b1;
        meas(1, 1'b0, w);
        check(w >= HOFF - 2 && w <= HOFF + 2, 1'b1);
        meas(1, 1'b1, w);
        check(w >= HON - 2 && w <= HON + 2, 1'b1);
        rd(12'h008, 32'h0000_0010, 1'b0);
        @(posedge clk) boost_oc_cmp <= 1'b0;
        settle(300);
        check(reverse_block_switch, 1'b1);
        rd(12'h008, 32'h0000_0000, 1'b0);
        fault2(32'h0000_0004);
        // Boost overvoltage drops the enable bit
        @(posedge clk) boost_ov_cmp <= 1'b1;
        meas(0, 1'b0, w);
        check(w, INTC);
        rd(12'h000, 32'h0000_0000, 1'b0);
        @(posedge clk) boost_ov_cmp <= 1'b0;
        fault2(32'h0000_0004);
        // Overcurrent latch and each of its four release events
        @(posedge clk) adapter_present <= 1'b0;
        for (int e = 0; e < 4; e++) begin
            @(posedge clk) sys_overcurrent <= 1'b1;
            @(posedge clk) sys_overcurrent <= 1'b0;
            settle(8);
            check(battery_switch, 1'b0);
            if (e == 0) rd(12'h008, 32'h0000_0004, 1'b0);
            if (e == 0) @(posedge clk) push_button_pin <= 1'b0;
            if (e == 0) settle(20);
            if (e == 0) @(posedge clk) push_button_pin <= 1'b1;
            if (e == 1 || e == 2) wr(12'h000, 32'h0000_0002);
            if (e == 1 || e == 2) wr(12'h000, (e == 2) ? 32'h0000_0004 : 32'h0000_0000);
            if (e == 3) @(posedge clk) adapter_present <= 1'b1;
            if (e == 3) settle(8);
            if (e == 3) @(posedge clk) adapter_present <= 1'b0;
            settle(10);
            check(battery_switch, 1'b1);
        end
        // Over-discharge: stays off until an input source appears
        @(posedge clk) bat_overdischarge <= 1'b1;
        {bat_short_cmp, bat_low_cmp} <= 2'b00;
        settle(6);
        check(battery_switch, 1'b0);
        @(posedge clk) bat_overdischarge <= 1'b0;
        settle(6);
        check(battery_switch, 1'b0);
        @(posedge clk) adapter_present <= 1'b1;
        settle(6);
        check({battery_switch, charge_current_sel}, 3'b101);
        @(posedge clk) bat_short_cmp <= 1'b1;
        settle(6);
        check(charge_current_sel, 2'b10);
        final_report;
    end
endmodule // tb_top
